// ===== hw/sasq_sequencer.sv
`timescale 1ns/100ps
// Behaviour
// - clear the approximation register to zero at every conversion start.
// - first trial sets bit 7, then the comparator is evaluated.
// - keep trial bit when reference below input, else clear it.
// - reference code output equals the approximation register.
// - decide bits 7 to 0, then copy value into channel result register.
// - each channel conversion takes exactly 57 converter clocks.
// - control bits 4:3 select one-shot, repeat, single sweep, repeat sweep.
// - internal trigger: setting start flag begins conversion immediately.
// - external trigger: start on falling trigger pin edge while flag is one.
// - one-shot internal: store, raise request, clear start flag, halt.
// - one-shot external: store, raise request, keep start flag at one.
// - one-shot external: falling edge mid-conversion restarts from bit 7.
// - repeat mode converts continuously, no request, flag untouched.
// - one-shot and repeat convert only the selected channel.
// - sweep modes convert 2, 4, 6 or 8 channels, ignore channel field.
// - sweep starts at channel 0 ascending, storing each result at once.
// - single sweep end raises request; internal trigger also clears flag.
// - single sweep external: flag stays; falling edge restarts from channel 0.
// - repeat sweep wraps to channel 0 without request until flag cleared.
// - trigger source bit: zero software flag, one external falling edge.
// - clock select bit: zero divides by 8, one divides by 4.
// - sweep field maps to groups 0-1, 0-3, 0-5, 0-7; resets to 11.
// - request bit clears on acceptance; software may set or clear it.
module sasq_sequencer
#(
	parameter int SLOT_TICKS = sasq_pkg::SLOT_CYCLES // converter clocks per bit
)
(
	input  wire logic                       clk,            // 200 MHz clock
	input  wire logic                       resetn,         // async reset
	input  wire logic [sasq_pkg::ADDR_W-1:0] addr,           // register address
	input  wire logic [sasq_pkg::DATA_W-1:0] wdata,          // write data
	input  wire logic                       wr,             // write strobe
	input  wire logic                       rd,             // read strobe
	output logic      [sasq_pkg::DATA_W-1:0] rdata,          // read data
	input  wire logic                       irq_ack,        // request accepted
	input  wire logic                       cmp_ref_below,  // comparator pin
	input  wire logic                       ext_convert_trigger_n, // trigger pin
	output logic      [sasq_pkg::DATA_W-1:0] ref_code,       // ladder code
	output logic      [2:0]                 analog_channel_sel, // mux select
	output logic                            irq_req,        // request bit
	output logic                            busy            // converting
);
	import sasq_pkg::*;

	// refuse slot lengths that break the conversion length
	if (1 + SAR_BITS * SLOT_TICKS != CONV_CYCLES)
		$error("slot length does not give the conversion length");

	localparam logic [2:0] SLOT_LAST = 3'(SLOT_TICKS - 1);

	sasq_state_t state;
	sasq_mode_t  mode;
	logic [2:0]  ch_field;
	logic        trig_ext;
	logic        start_flag;
	logic        clk_fast;
	logic [1:0]  sweep_field;
	logic [2:0]  irq_level;
	logic [7:0]  results [0:N_CH-1];
	logic        cmp_meta;
	logic        cmp_s;
	logic        trg_meta;
	logic        trg_s;
	logic        trg_d;
	logic [2:0]  div_cnt;
	logic [2:0]  slot;
	logic [2:0]  bit_idx;
	logic        init;
	logic [7:0]  sar_dec;
	logic        tick;
	logic        fall;
	logic        trigger;
	logic        decide;
	logic        done;
	logic        sweeping;
	logic        at_last;
	logic        keep_going;
	logic        irq_set;
	logic        hw_clear;
	logic        wr_ctrl;
	logic        wr_irq;
	logic        is_res;
	logic [5:0]  conv_ticks;

	// two-flop synchronisers for comparator and trigger pin
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			cmp_meta <= 1'b0;
			cmp_s    <= 1'b0;
			trg_meta <= 1'b1;
			trg_s    <= 1'b1;
			trg_d    <= 1'b1;
		end
		else
		begin
			cmp_meta <= cmp_ref_below;
			cmp_s    <= cmp_meta;
			trg_meta <= ext_convert_trigger_n;
			trg_s    <= trg_meta;
			trg_d    <= trg_s;
		end
	end

	// converter clock tick, divide by 8 or 4
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			div_cnt <= 3'h0;
		else if (div_cnt >= (clk_fast ? DIV_FAST_LAST : DIV_SLOW_LAST))
			div_cnt <= 3'h0;
		else
			div_cnt <= div_cnt + 3'h1;
	end

	// sequencing decode
	always_comb
	begin
		tick     = (div_cnt == (clk_fast ? DIV_FAST_LAST : DIV_SLOW_LAST));
		fall     = trg_d && !trg_s;
		// internal source: flag while idle; external: falling edge with flag
		trigger  = start_flag && (trig_ext ? fall : (state == ST_IDLE));
		sweeping = (mode == MODE_SWEEP1) || (mode == MODE_SWEEPR);
		at_last  = (analog_channel_sel == {sweep_field, 1'b1});
		decide   = (state == ST_CONV) && tick && !init && (slot == SLOT_LAST);
		done     = decide && (bit_idx == 3'h0) && !trigger && start_flag;
		keep_going = (mode == MODE_REPEAT) || (mode == MODE_SWEEPR)
			|| ((mode == MODE_SWEEP1) && !at_last);
		irq_set  = done && ((mode == MODE_ONESHOT)
			|| ((mode == MODE_SWEEP1) && at_last));
		hw_clear = irq_set && !trig_ext;
		wr_ctrl  = wr && (addr == OFF_CTRL);
		wr_irq   = wr && (addr == OFF_IRQ);
		is_res   = (addr[7:4] == OFF_RES_BASE[7:4]) && !addr[0];
	end

	// trial bit takes the comparator verdict
	always_comb
	begin
		sar_dec          = ref_code;
		sar_dec[bit_idx] = cmp_s;
	end

	// control and sweep register fields
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			ch_field    <= CH_RESET;
			mode        <= MODE_ONESHOT;
			trig_ext    <= 1'b0;
			clk_fast    <= 1'b0;
			sweep_field <= SWEEP_RESET;
		end
		else
		begin
			if (wr_ctrl)
			begin
				ch_field <= wdata[CTRL_CH_LO +: 3];
				mode     <= sasq_mode_t'(wdata[CTRL_MODE_LO +: 2]);
				trig_ext <= wdata[CTRL_TRIG];
				clk_fast <= wdata[CTRL_CLK];
			end
			if (wr && (addr == OFF_SWEEP))
				sweep_field <= wdata[1:0];
		end
	end

	// start flag, a software write of one beats the hardware clear
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			start_flag <= 1'b0;
		else if (wr_ctrl)
			start_flag <= wdata[CTRL_START];
		else if (hw_clear)
			start_flag <= 1'b0;
	end

	// interrupt request bit and priority level, the set wins
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			irq_req   <= 1'b0;
			irq_level <= LVL_RESET;
		end
		else
		begin
			if (irq_set)
				irq_req <= 1'b1;
			else if (wr_irq)
				irq_req <= wdata[IRQ_REQ_BIT];
			else if (irq_ack)
				irq_req <= 1'b0;
			if (wr_irq)
				irq_level <= wdata[2:0];
		end
	end

	// conversion state machine and approximation register
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			state              <= ST_IDLE;
			busy               <= 1'b0;
			ref_code           <= SAR_CLEAR;
			init               <= 1'b0;
			slot               <= 3'h0;
			bit_idx            <= MSB_IDX;
			analog_channel_sel <= CH_RESET;
		end
		else if (trigger)
		begin
			// start or retrigger from bit 7 and channel 0 of a sweep
			state              <= ST_CONV;
			busy               <= 1'b1;
			ref_code           <= SAR_CLEAR;
			init               <= 1'b1;
			slot               <= 3'h0;
			bit_idx            <= MSB_IDX;
			analog_channel_sel <= sweeping ? 3'h0 : ch_field;
		end
		else if (!start_flag)
		begin
			// flag cleared: abandon any conversion
			state <= ST_IDLE;
			busy  <= 1'b0;
		end
		else
		begin
			case (state)
				ST_IDLE:
				begin
					busy <= 1'b0;
				end
				ST_CONV:
				begin
					if (tick && init)
					begin
						ref_code <= SAR_MSB;
						init     <= 1'b0;
						slot     <= 3'h0;
					end
					else if (done)
					begin
						ref_code <= SAR_CLEAR;
						init     <= 1'b1;
						bit_idx  <= MSB_IDX;
						slot     <= 3'h0;
						if (keep_going)
						begin
							// repeat, or next channel ascending
							if (mode == MODE_REPEAT)
								analog_channel_sel <= ch_field;
							else if (at_last)
								analog_channel_sel <= 3'h0;
							else
								analog_channel_sel <= analog_channel_sel + 3'h1;
						end
						else
						begin
							state <= ST_IDLE;
							busy  <= 1'b0;
						end
					end
					else if (decide)
					begin
						// verdict for this bit, trial for the next
						ref_code              <= sar_dec;
						ref_code[bit_idx - 3'h1] <= 1'b1;
						bit_idx               <= bit_idx - 3'h1;
						slot                  <= 3'h0;
					end
					else if (tick)
						slot <= slot + 3'h1;
				end
				default:
				begin
					state <= ST_IDLE;
					busy  <= 1'b0;
				end
			endcase
		end
	end

	// per-channel result registers
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			for (int i = 0; i < N_CH; i++)
				results[i] <= SAR_CLEAR;
		end
		else if (done)
			results[analog_channel_sel] <= sar_dec;
	end

	// register read port, data valid one cycle after the strobe
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			rdata <= 8'h00;
		else if (rd && (addr == OFF_CTRL))
			rdata <= {clk_fast, start_flag, trig_ext, mode, ch_field};
		else if (rd && (addr == OFF_SWEEP))
			rdata <= {6'h00, sweep_field};
		else if (rd && (addr == OFF_IRQ))
			rdata <= {4'h0, irq_req, irq_level};
		else if (rd && is_res)
			rdata <= results[addr[3:1]];
		else
			rdata <= 8'h00;
	end

	// converter clocks since start, for checking only
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			conv_ticks <= 6'h00;
		else if (trigger || done)
			conv_ticks <= 6'h00;
		else if (tick && (state == ST_CONV))
			conv_ticks <= conv_ticks + 6'h01;
	end

	conv_len_a: assert property (@(posedge clk) disable iff (!resetn)
		done |-> (conv_ticks == 6'(CONV_CYCLES - 1)))
		else $error("conversion length wrong");

	sar_clear_a: assert property (@(posedge clk) disable iff (!resetn)
		trigger |=> (ref_code == SAR_CLEAR) && init)
		else $error("register not cleared at start");

	msb_trial_a: assert property (@(posedge clk) disable iff (!resetn)
		(state == ST_CONV && init && tick && !trigger && start_flag)
		|=> (ref_code == SAR_MSB) ##1 (ref_code == SAR_MSB)[*2])
		else $error("first trial not bit 7");

	bit_verdict_a: assert property (@(posedge clk) disable iff (!resetn)
		(decide && !done && !trigger && start_flag)
		|=> (ref_code[$past(bit_idx)] == $past(cmp_s)))
		else $error("trial bit verdict wrong");

	result_store_a: assert property (@(posedge clk) disable iff (!resetn)
		done |=> (results[$past(analog_channel_sel)] == $past(sar_dec)))
		else $error("result not stored");

	oneshot_irq_a: assert property (@(posedge clk) disable iff (!resetn)
		(done && mode == MODE_ONESHOT)
		|=> irq_req && !busy
			&& (start_flag == ($past(wr_ctrl) ? $past(wdata[CTRL_START]) : $past(trig_ext))))
		else $error("one-shot completion wrong");

	repeat_quiet_a: assert property (@(posedge clk) disable iff (!resetn)
		(done && mode == MODE_REPEAT && !irq_req && !wr_irq)
		|=> !irq_req && busy
			&& (start_flag == ($past(wr_ctrl) ? $past(wdata[CTRL_START]) : 1'b1)))
		else $error("repeat mode raised request or stopped");

	sweep_wrap_a: assert property (@(posedge clk) disable iff (!resetn)
		(done && mode == MODE_SWEEPR && at_last)
		|=> (analog_channel_sel == 3'h0) && busy)
		else $error("repeat sweep did not wrap");

	tick_rate_a: assert property (@(posedge clk) disable iff (!resetn)
		tick |=> !tick[*3])
		else $error("converter clock too fast");

	ext_retrig_a: assert property (@(posedge clk) disable iff (!resetn)
		(trig_ext && start_flag && fall && sweeping)
		|=> (analog_channel_sel == 3'h0) && busy)
		else $error("retrigger did not restart at channel 0");
endmodule

// ===== hw/sasq_pkg.sv
package sasq_pkg;
	// register map and bus widths
	localparam int        ADDR_W       = 8;
	localparam int        DATA_W       = 8;
	localparam logic [7:0] OFF_CTRL     = 8'h1E;
	localparam logic [7:0] OFF_SWEEP    = 8'h1F;
	localparam logic [7:0] OFF_RES_BASE = 8'h20;
	localparam logic [7:0] OFF_IRQ      = 8'h70;
	// control and request register field positions
	localparam int        CTRL_CH_LO   = 0;
	localparam int        CTRL_MODE_LO = 3;
	localparam int        CTRL_TRIG    = 5;
	localparam int        CTRL_START   = 6;
	localparam int        CTRL_CLK     = 7;
	localparam int        IRQ_REQ_BIT  = 3;
	// reset values and first trial code
	localparam logic [1:0] SWEEP_RESET = 2'h3;
	localparam logic [2:0] CH_RESET    = 3'h0;
	localparam logic [2:0] LVL_RESET   = 3'h0;
	localparam logic [7:0] SAR_CLEAR   = 8'h00;
	localparam logic [7:0] SAR_MSB     = 8'h80;
	// converter clock dividers, conversion timing in converter clocks, bit and channel counts
	localparam logic [2:0] DIV_SLOW_LAST = 3'h7;
	localparam logic [2:0] DIV_FAST_LAST = 3'h3;
	localparam int        CONV_CYCLES   = 57;
	localparam int        SLOT_CYCLES   = 7;
	localparam int        SAR_BITS      = 8;
	localparam int        N_CH          = 8;
	localparam logic [2:0] MSB_IDX      = 3'h7;
	// conversion modes
	typedef enum logic [1:0] {
		MODE_ONESHOT = 2'h0,
		MODE_REPEAT  = 2'h1,
		MODE_SWEEP1  = 2'h2,
		MODE_SWEEPR  = 2'h3
	} sasq_mode_t;
	// sequencer states
	typedef enum logic [1:0] {
		ST_IDLE = 2'h1,
		ST_CONV = 2'h2
	} sasq_state_t;
endpackage

// ===== testbench/sasq_adc_model.sv
`timescale 1ns/100ps
// comparator and ladder seen from the analog side of the converter
module sasq_adc_model
(
	input  wire logic [7:0] ref_code,           // ladder code from the sequencer
	input  wire logic [2:0] analog_channel_sel, // channel on the mux
	output logic            cmp_ref_below       // 1 while reference is under input
);
	logic [7:0] vin_code;

	// each input sits exactly on a code and never moves during a conversion
	assign vin_code = 8'h1B + {5'h00, analog_channel_sel} * 8'h1D;
	// ladder gives (n - 0.5) lsb for n > 0 and 0 for n = 0, so ref < vin iff n <= vin
	assign cmp_ref_below = (ref_code <= vin_code);
endmodule

// ===== testbench/sasq_sequencer_bench.sv
`timescale 1ns/100ps
module sasq_sequencer_bench;
	import sasq_pkg::*;
	logic                clk;
	logic                resetn;
	logic [ADDR_W-1:0]   addr;
	logic [DATA_W-1:0]   wdata;
	logic                wr;
	logic                rd;
	logic [DATA_W-1:0]   rdata;
	logic                irq_ack;
	logic                cmp_ref_below;
	logic                trig_n;
	logic [DATA_W-1:0]   ref_code;
	logic [2:0]          analog_channel_sel;
	logic                irq_req;
	logic                busy;
	int                  err_count;
	int                  comparisons;
	int                  n;

	sasq_sequencer dut_u (.clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata), .irq_ack(irq_ack), .cmp_ref_below(cmp_ref_below),
		.ext_convert_trigger_n(trig_n), .ref_code(ref_code),
		.analog_channel_sel(analog_channel_sel), .irq_req(irq_req), .busy(busy));
	sasq_adc_model model_u (.ref_code(ref_code), .analog_channel_sel(analog_channel_sel),
		.cmp_ref_below(cmp_ref_below));

	// 200 MHz clock
	always #2.5 clk = ~clk;

	// compare one value
	task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
		comparisons++;
		if (seen !== exp)
		begin
			err_count++;
			$display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask

	// one-cycle write strobe
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	// one-cycle read strobe, data taken in the following cycle
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string what);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		check(rdata, exp, what);
	endtask

	// count cycles until the converter goes idle
	task automatic wait_idle(output int cnt);
		cnt = 0;
		do
		begin
			@(posedge clk);
			#1;
			cnt++;
		end
		while (busy === 1'b1 && cnt < 8000);
	endtask

	// falling then rising edge on the trigger pin
	task automatic pulse_trig();
		@(posedge clk);
		trig_n <= 1'b0;
		repeat (12) @(posedge clk);
		trig_n <= 1'b1;
	endtask

	function automatic logic [7:0] vin(input int ch);
		return 8'h1B + 8'(ch) * 8'h1D;
	endfunction

	function automatic logic [7:0] in_range(input int v, input int lo, input int hi);
		return {7'h00, (v >= lo && v <= hi)};
	endfunction

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// watchdog against a hung conversion
	initial
	begin
		#(60000 * 5);
		err_count++;
		print_verdict();
	end

	initial
	begin
		clk = 1'b0;
		resetn = 1'b0;
		addr = 8'h00;
		wdata = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
		irq_ack = 1'b0;
		trig_n = 1'b1;
		err_count = 0;
		comparisons = 0;
		repeat (8) @(posedge clk);
		resetn <= 1'b1;
		// reset values, unmapped and read-only places
		rd_chk(OFF_CTRL, 8'h00, "ctrl reset");
		rd_chk(OFF_SWEEP, 8'h03, "sweep reset");
		rd_chk(OFF_IRQ, 8'h00, "irq reset");
		wr_reg(OFF_RES_BASE, 8'h5A);
		rd_chk(OFF_RES_BASE, 8'h00, "result read-only");
		rd_chk(8'h50, 8'h00, "unmapped");
		$display("test reset done");
		// one-shot internal on channel 5, divide by 8
		wr_reg(OFF_CTRL, 8'h45);
		@(posedge clk);
		#1;
		check(ref_code, SAR_CLEAR, "sar cleared");
		wait (ref_code !== 8'h00);
		#1;
		check(ref_code, SAR_MSB, "msb trial first");
		wait_idle(n);
		check(in_range(n, 448, 466), 8'h01, "57 ticks of 8");
		check({7'h00, irq_req}, 8'h01, "oneshot irq");
		rd_chk(OFF_CTRL, 8'h05, "start cleared");
		rd_chk(OFF_RES_BASE + 8'h0A, vin(5), "ch5 result");
		rd_chk(OFF_RES_BASE + 8'h08, 8'h00, "ch4 untouched");
		// request bit by software and by acceptance
		wr_reg(OFF_IRQ, 8'h00);
		rd_chk(OFF_IRQ, 8'h00, "irq cleared");
		wr_reg(OFF_IRQ, 8'h0D);
		rd_chk(OFF_IRQ, 8'h0D, "irq set by write");
		@(posedge clk);
		irq_ack <= 1'b1;
		@(posedge clk);
		irq_ack <= 1'b0;
		rd_chk(OFF_IRQ, 8'h05, "irq cleared on accept");
		$display("test oneshot done");
		// one-shot internal on channel 3, divide by 4
		wr_reg(OFF_CTRL, 8'hC3);
		wait_idle(n);
		check(in_range(n, 224, 236), 8'h01, "57 ticks of 4");
		rd_chk(OFF_RES_BASE + 8'h06, vin(3), "ch3 result");
		wr_reg(OFF_IRQ, 8'h00);
		$display("test fast clock done");
		// repeat mode on channel 2
		wr_reg(OFF_CTRL, 8'h4A);
		repeat (1400) @(posedge clk);
		#1;
		check({6'h00, irq_req, busy}, 8'h01, "repeat runs without irq");
		rd_chk(OFF_CTRL, 8'h4A, "repeat keeps flag");
		rd_chk(OFF_RES_BASE + 8'h04, vin(2), "ch2 result");
		wr_reg(OFF_CTRL, 8'h0A);
		wait_idle(n);
		check(in_range(n, 1, 3), 8'h01, "stop on flag clear");
		$display("test repeat done");
		// single sweep over 0-3, channel field ignored
		wr_reg(OFF_SWEEP, 8'h01);
		wr_reg(OFF_CTRL, 8'h57);
		wait_idle(n);
		check(in_range(n, 4 * 448, 4 * 466), 8'h01, "four channels");
		for (int ch = 0; ch < 4; ch++)
			rd_chk(OFF_RES_BASE + 8'(2 * ch), vin(ch), "sweep result");
		rd_chk(OFF_RES_BASE + 8'h08, 8'h00, "ch4 outside group");
		check({7'h00, irq_req}, 8'h01, "sweep irq");
		rd_chk(OFF_CTRL, 8'h17, "sweep clears flag");
		wr_reg(OFF_IRQ, 8'h00);
		$display("test single sweep done");
		// repeat sweep over 0-1
		wr_reg(OFF_SWEEP, 8'h00);
		wr_reg(OFF_CTRL, 8'h5C);
		repeat (2000) @(posedge clk);
		#1;
		check({6'h00, irq_req, busy}, 8'h01, "repeat sweep no irq");
		wr_reg(OFF_CTRL, 8'h1C);
		wait_idle(n);
		check(in_range(n, 1, 3), 8'h01, "repeat sweep stops on clear");
		rd_chk(OFF_RES_BASE + 8'h08, 8'h00, "sweep ignores channel field");
		$display("test repeat sweep done");
		// external trigger, one-shot on channel 6, with retrigger
		wr_reg(OFF_CTRL, 8'h66);
		repeat (40) @(posedge clk);
		#1;
		check({7'h00, busy}, 8'h00, "no start without edge");
		pulse_trig();
		repeat (200) @(posedge clk);
		pulse_trig();
		wait_idle(n);
		check(in_range(n, 430, 470), 8'h01, "restart from msb");
		check({7'h00, irq_req}, 8'h01, "ext oneshot irq");
		rd_chk(OFF_CTRL, 8'h66, "ext keeps flag");
		rd_chk(OFF_RES_BASE + 8'h0C, vin(6), "ch6 result");
		wr_reg(OFF_IRQ, 8'h00);
		$display("test external oneshot done");
		// external single sweep over 0-1, retrigger during channel 1
		wr_reg(OFF_CTRL, 8'h70);
		pulse_trig();
		repeat (600) @(posedge clk);
		pulse_trig();
		repeat (30) @(posedge clk);
		#1;
		check({5'h00, analog_channel_sel}, 8'h00, "sweep restarts at ch0");
		wait_idle(n);
		check({7'h00, irq_req}, 8'h01, "ext sweep irq");
		rd_chk(OFF_CTRL, 8'h70, "ext sweep keeps flag");
		$display("test external sweep done");
		print_verdict();
	end
endmodule
